// *** rtl/sfrp_pkg.sv ***
// Constants and types for the serial flash read-path host controller.
package sfrp_pkg;

   // ----------------------------------------------------------------
   // Instruction codes
   // ----------------------------------------------------------------
   localparam logic [7:0] OP_EN4B = 8'hb7;
   localparam logic [7:0] OP_EX4B = 8'he9;
   localparam logic [7:0] OP_READ = 8'h03;
   localparam logic [7:0] OP_READ4 = 8'h13;
   localparam logic [7:0] OP_FAST = 8'h0b;
   localparam logic [7:0] OP_FAST4 = 8'h0c;
   localparam logic [7:0] OP_DOUT = 8'h3b;
   localparam logic [7:0] OP_DOUT4 = 8'h3c;
   localparam logic [7:0] OP_QOUT = 8'h6b;
   localparam logic [7:0] OP_QOUT4 = 8'h6c;
   localparam logic [7:0] OP_DIO = 8'hbb;
   localparam logic [7:0] OP_DIO4 = 8'hbc;
   localparam logic [7:0] OP_QIO = 8'heb;
   localparam logic [7:0] OP_SETWRAP = 8'h77;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 25;
   localparam int SCLK_PERIOD_NS = 200;
   localparam int SCLK_DIV = SCLK_PERIOD_NS / CLK_PERIOD_NS;
   localparam logic [2:0] PH_RISE = 3'(SCLK_DIV / 2 - 1);
   localparam logic [2:0] PH_LAST = 3'(SCLK_DIV - 1);
   localparam logic [5:0] CS_GAP_CYCLES = 6'h08;

   // ----------------------------------------------------------------
   // Instruction shape
   // ----------------------------------------------------------------
   localparam logic [5:0] OPC_BITS = 6'h08;
   localparam logic [5:0] ADDR3_BITS = 6'h18;
   localparam logic [5:0] ADDR4_BITS = 6'h20;
   localparam logic [5:0] WRAP_BITS = 6'h08;
   localparam logic [5:0] DUMMY_FAST = 6'h08;
   localparam logic [5:0] DUMMY_DIO = 6'h04;
   localparam logic [5:0] DUMMY_QIO = 6'h06;
   localparam logic [2:0] LANE1 = 3'h1;
   localparam logic [2:0] LANE2 = 3'h2;
   localparam logic [2:0] LANE4 = 3'h4;
   localparam logic [1:0] AM_NONE = 2'h0;
   localparam logic [1:0] AM_MODE = 2'h1;
   localparam logic [1:0] AM_FIX32 = 2'h2;

   // ----------------------------------------------------------------
   // Wrap setting and reset values
   // ----------------------------------------------------------------
   localparam int WRAP_DIS_POS = 4;
   localparam int WRAP_LEN_LSB = 5;
   localparam logic [7:0] WRAP_USED_MASK = 8'h70;
   localparam logic [7:0] WRAP_RESET = 8'h10;
   localparam logic ADDR4_RESET = 1'b0;

   typedef enum logic [2:0] {ST_IDLE, ST_OPC, ST_ADDR, ST_WBITS, ST_DUMMY, ST_DATA, ST_GAP} sfrp_state_e;

   typedef struct packed {
      logic [1:0] addr_mode;
      logic [2:0] addr_lanes;
      logic [2:0] data_lanes;
      logic [5:0] dummy;
      logic wrap_cfg;
   } sfrp_opinfo_s;

endpackage

// *** rtl/sfrp_host_ctrl.sv ***
// Host-side SPI controller that issues read, address-mode and wrap instructions to a serial flash.
`timescale 1ns/100ps
// Overview of operation
// RULE1 - Opcode B7h in its own chip-select frame switches the flash to 32-bit addressing.
// RULE2 - Opcode E9h in its own frame returns the flash to 24-bit addressing.
// RULE3 - In 3-byte mode only the extended register reaches above 128Mb, not address bits.
// RULE4 - Mode-dependent reads carry 32 address bits in 4-byte mode, else 24.
// RULE5 - Plain read sends 03h then address on line zero, sampled on rising edges.
// RULE6 - Single-line read data comes out on falling edges, most significant bit first.
// RULE7 - The flash increments the address after each byte until chip select rises.
// RULE8 - Reads issued while the flash is busy are ignored without disturbing it.
// RULE9 - Plain read has no dummy clocks; data follows the last address bit directly.
// RULE10 - Opcode 13h always carries 32 address bits, otherwise like plain read.
// RULE11 - Opcode 0Bh has eight dummy clocks after the address; output ignored then.
// RULE12 - Opcode 0Ch is the fast read with a fixed 32-bit address.
// RULE13 - Opcode 3Bh returns data two bits per clock after eight dummy clocks.
// RULE14 - The host releases all output lines before the first data-out falling edge; for 03h/13h line zero is released one i_clock cycle after it.
// RULE15 - Opcode 3Ch is the dual-output read with a fixed 32-bit address.
// RULE16 - Opcode 6Bh returns data four bits per clock after eight dummy clocks.
// RULE17 - Opcode 6Ch is the quad-output read with a fixed 32-bit address.
// RULE18 - Opcode BBh sends address two bits per clock, four dummy clocks, dual data.
// RULE19 - Opcode BCh is the dual I/O read with a fixed 32-bit address.
// RULE20 - Opcode EBh moves address and data four bits per clock, six dummy clocks.
// RULE21 - With wrap on, the quad I/O read wraps inside an aligned page section.
// RULE22 - Opcode 77h sets wrap on or off and a two-bit section length.
// RULE23 - 77h carries 24 or 32 dummy bits then eight wrap bits; W7 and low nibble unused.
// RULE24 - Wrap-disable bit low selects 8/16/32/64 bytes; it resets to one.
// RULE25 - In 3-byte mode the extended register supplies the top address byte.
// RULE26 - The flash decodes the first eight bits after chip select falls; rise aborts.
module sfrp_host_ctrl
   import sfrp_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic i_cmd_valid,
   input wire logic [7:0] i_cmd_opcode,
   input wire logic [31:0] i_cmd_addr,
   input wire logic [15:0] i_cmd_len_m1,
   input wire logic i_dev_busy,
   output logic o_cmd_ready,
   output logic [7:0] o_rd_data,
   output logic o_rd_valid,
   output logic o_addr4_mode,
   output logic [7:0] o_wrap_bits,
   output logic o_cs_n,
   output logic o_sclk,
   output logic [3:0] o_io_out,
   output logic [3:0] o_io_oe_n,
   input wire logic [3:0] i_io_in
);

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic sfrp_opinfo_s decode(input logic [7:0] op);
      sfrp_opinfo_s d;
      d = '{addr_mode: AM_NONE, addr_lanes: LANE1, data_lanes: LANE1, dummy: 6'h00, wrap_cfg: 1'b0};
      case (op)
         OP_READ: d.addr_mode = AM_MODE;
         // RULE10 fixed 32-bit address
         OP_READ4: d.addr_mode = AM_FIX32;
         // RULE12 fast fixed width
         OP_FAST, OP_FAST4: begin
            d.addr_mode = (op == OP_FAST) ? AM_MODE : AM_FIX32;
            d.dummy = DUMMY_FAST;
         end
         // RULE13 dual data lanes
         // RULE15 dual fixed width
         OP_DOUT, OP_DOUT4: begin
            d.addr_mode = (op == OP_DOUT) ? AM_MODE : AM_FIX32;
            d.dummy = DUMMY_FAST;
            d.data_lanes = LANE2;
         end
         // RULE16 quad data lanes
         // RULE17 quad fixed width
         OP_QOUT, OP_QOUT4: begin
            d.addr_mode = (op == OP_QOUT) ? AM_MODE : AM_FIX32;
            d.dummy = DUMMY_FAST;
            d.data_lanes = LANE4;
         end
         // RULE18 dual address lanes
         // RULE19 dual I/O fixed width
         OP_DIO, OP_DIO4: begin
            d.addr_mode = (op == OP_DIO) ? AM_MODE : AM_FIX32;
            d.dummy = DUMMY_DIO;
            d.addr_lanes = LANE2;
            d.data_lanes = LANE2;
         end
         // RULE20 quad address lanes
         OP_QIO: begin
            d.addr_mode = AM_MODE;
            d.dummy = DUMMY_QIO;
            d.addr_lanes = LANE4;
            d.data_lanes = LANE4;
         end
         OP_SETWRAP: begin
            d.addr_mode = AM_MODE;
            d.addr_lanes = LANE4;
            d.wrap_cfg = 1'b1;
         end
         default: d.addr_mode = AM_NONE;
      endcase
      return d;
   endfunction

   function automatic logic [5:0] clocks(input logic [5:0] bits, input logic [2:0] lanes);
      case (lanes)
         LANE2: return bits >> 1;
         LANE4: return bits >> 2;
         default: return bits;
      endcase
   endfunction

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   sfrp_state_e state_r, state_nxt;
   sfrp_opinfo_s info_r;
   logic [7:0] op_r;
   logic [31:0] addr_r;
   logic [15:0] len_r;
   logic [2:0] ph_r;
   logic [5:0] cnt_r, cnt_nxt;
   logic [31:0] tx_r, tx_nxt;
   logic [2:0] lanes_r, lanes_nxt;
   logic [7:0] rx_r;
   logic [3:0] io_s1_r, io_s2_r;
   logic [5:0] alen;
   logic [5:0] stg_clk_r;
   logic [7:0] rx_shift;
   logic take, blocked, clk_end, stg_end, active;
   sfrp_opinfo_s cmd_info;

   assign cmd_info = decode(i_cmd_opcode);
   assign blocked = i_dev_busy && (cmd_info.addr_mode != AM_NONE) && !cmd_info.wrap_cfg;
   assign take = (state_r == ST_IDLE) && i_cmd_valid && o_cmd_ready && !blocked;
   assign active = (state_r != ST_IDLE) && (state_r != ST_GAP);
   assign clk_end = active && (ph_r == PH_LAST);
   assign stg_end = clk_end && (cnt_r == 6'h00);
   assign alen = (info_r.addr_mode == AM_FIX32) ? ADDR4_BITS :
                 (info_r.addr_mode == AM_MODE) ? (o_addr4_mode ? ADDR4_BITS : ADDR3_BITS) : 6'h00;

   // ----------------------------------------------------------------
   // Stage sequencing
   // ----------------------------------------------------------------
   always_comb begin
      state_nxt = ST_GAP;
      cnt_nxt = CS_GAP_CYCLES - 6'h01;
      tx_nxt = 32'h0000_0000;
      lanes_nxt = info_r.data_lanes;
      case (state_r)
         ST_OPC: begin
            if (alen != 6'h00) begin
               // RULE4 address length
               state_nxt = ST_ADDR;
               cnt_nxt = clocks(alen, info_r.addr_lanes) - 6'h01;
               lanes_nxt = info_r.addr_lanes;
               // RULE23 dummy bits
               if (info_r.wrap_cfg) begin
                  tx_nxt = 32'h0000_0000;
               end else if (alen == ADDR4_BITS) begin
                  tx_nxt = addr_r;
               end else begin
                  // RULE3 low bytes only
                  tx_nxt = {addr_r[23:0], 8'h00};
               end
            end
         end
         ST_ADDR: begin
            if (info_r.wrap_cfg) begin
               state_nxt = ST_WBITS;
               cnt_nxt = clocks(WRAP_BITS, info_r.addr_lanes) - 6'h01;
               lanes_nxt = info_r.addr_lanes;
               tx_nxt = {addr_r[7:0], 24'h00_0000};
            end else if (info_r.dummy != 6'h00) begin
               // RULE11 dummy clocks
               state_nxt = ST_DUMMY;
               cnt_nxt = info_r.dummy - 6'h01;
            end else begin
               // RULE9 no dummy
               state_nxt = ST_DATA;
               cnt_nxt = clocks(OPC_BITS, info_r.data_lanes) - 6'h01;
            end
         end
         ST_DUMMY: begin
            state_nxt = ST_DATA;
            cnt_nxt = clocks(OPC_BITS, info_r.data_lanes) - 6'h01;
         end
         ST_DATA: begin
            if (len_r != 16'h0000) begin
               state_nxt = ST_DATA;
               cnt_nxt = clocks(OPC_BITS, info_r.data_lanes) - 6'h01;
            end
         end
         default: state_nxt = ST_GAP;
      endcase
   end

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         state_r <= ST_IDLE;
         ph_r <= 3'h0;
         cnt_r <= 6'h00;
         tx_r <= 32'h0000_0000;
         lanes_r <= LANE1;
         op_r <= 8'h00;
         addr_r <= 32'h0000_0000;
         len_r <= 16'h0000;
         info_r <= '0;
         stg_clk_r <= 6'h00;
      end else begin
         case (state_r)
            ST_IDLE: begin
               if (take) begin
                  // RULE26 opcode first
                  state_r <= ST_OPC;
                  ph_r <= 3'h0;
                  cnt_r <= OPC_BITS - 6'h01;
                  tx_r <= {i_cmd_opcode, 24'h00_0000};
                  lanes_r <= LANE1;
                  op_r <= i_cmd_opcode;
                  addr_r <= i_cmd_addr;
                  len_r <= i_cmd_len_m1;
                  info_r <= decode(i_cmd_opcode);
                  stg_clk_r <= 6'h00;
               end
            end
            ST_GAP: begin
               if (cnt_r == 6'h00) begin
                  state_r <= ST_IDLE;
               end else begin
                  cnt_r <= cnt_r - 6'h01;
               end
            end
            default: begin
               ph_r <= (ph_r == PH_LAST) ? 3'h0 : ph_r + 3'h1;
               if (stg_end) begin
                  state_r <= state_nxt;
                  cnt_r <= cnt_nxt;
                  tx_r <= tx_nxt;
                  lanes_r <= lanes_nxt;
                  stg_clk_r <= 6'h00;
                  if (state_r == ST_DATA) begin
                     len_r <= len_r - 16'h0001;
                  end
               end else if (clk_end) begin
                  cnt_r <= cnt_r - 6'h01;
                  tx_r <= tx_r << lanes_r;
                  stg_clk_r <= stg_clk_r + 6'h01;
               end
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Ready, address mode and wrap shadow
   // ----------------------------------------------------------------
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         o_cmd_ready <= 1'b0;
      end else begin
         // RULE8 busy refusal
         o_cmd_ready <= ((state_r == ST_IDLE) && !take) || ((state_r == ST_GAP) && (cnt_r == 6'h00));
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         o_addr4_mode <= ADDR4_RESET;
         o_wrap_bits <= WRAP_RESET;
      end else if (stg_end) begin
         // RULE1 enter wide addressing
         if ((state_r == ST_OPC) && (op_r == OP_EN4B)) begin
            o_addr4_mode <= 1'b1;
         end
         // RULE2 leave wide addressing
         if ((state_r == ST_OPC) && (op_r == OP_EX4B)) begin
            o_addr4_mode <= 1'b0;
         end
         // RULE22 wrap setting kept
         if (state_r == ST_WBITS) begin
            o_wrap_bits <= addr_r[7:0] & WRAP_USED_MASK;
         end
      end
   end

   // ----------------------------------------------------------------
   // Pins
   // ----------------------------------------------------------------
   // Pins lag the state by one cycle, so edges keep their spacing and data changes one cycle after each falling edge.
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         o_cs_n <= 1'b1;
         o_sclk <= 1'b0;
         o_io_out <= 4'h0;
         o_io_oe_n <= 4'hf;
      end else begin
         o_cs_n <= !active;
         if (active && (ph_r == PH_RISE)) begin
            o_sclk <= 1'b1;
         end else if (!active || (ph_r == PH_LAST)) begin
            o_sclk <= 1'b0;
         end
         // RULE5 serial line zero
         case (lanes_r)
            LANE2: o_io_out <= {2'b00, tx_r[31:30]};
            LANE4: o_io_out <= tx_r[31:28];
            default: o_io_out <= {3'b000, tx_r[31]};
         endcase
         // RULE14 release before data
         if ((state_r == ST_OPC) || (state_r == ST_ADDR) || (state_r == ST_WBITS)) begin
            o_io_oe_n <= (lanes_r == LANE4) ? 4'h0 : (lanes_r == LANE2) ? 4'hc : 4'he;
         end else begin
            o_io_oe_n <= 4'hf;
         end
      end
   end

   // ----------------------------------------------------------------
   // Receive path
   // ----------------------------------------------------------------
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         io_s1_r <= 4'h0;
         io_s2_r <= 4'h0;
      end else begin
         io_s1_r <= i_io_in;
         io_s2_r <= io_s1_r;
      end
   end

   always_comb begin
      case (lanes_r)
         LANE2: rx_shift = {rx_r[5:0], io_s2_r[1:0]};
         LANE4: rx_shift = {rx_r[3:0], io_s2_r};
         default: rx_shift = {rx_r[6:0], io_s2_r[1]};
      endcase
   end

   // Sampling just before the falling edge gives the synchroniser most of a clock to settle.
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         rx_r <= 8'h00;
         o_rd_data <= 8'h00;
         o_rd_valid <= 1'b0;
      end else begin
         o_rd_valid <= 1'b0;
         if (clk_end && (state_r == ST_DATA)) begin
            // RULE6 most significant first
            rx_r <= rx_shift;
            if (cnt_r == 6'h00) begin
               o_rd_data <= rx_shift;
               o_rd_valid <= 1'b1;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   property p_enter4;
      @(posedge i_clock) disable iff (i_rst)
         (stg_end && state_r == ST_OPC && op_r == OP_EN4B) |=> o_addr4_mode;
   endproperty
   a_enter4: assert property (p_enter4) else $error("B7h did not set 4-byte mode"); // RULE1

   property p_exit4;
      @(posedge i_clock) disable iff (i_rst)
         (stg_end && state_r == ST_OPC && op_r == OP_EX4B) |=> !o_addr4_mode;
   endproperty
   a_exit4: assert property (p_exit4) else $error("E9h did not clear 4-byte mode"); // RULE2

   property p_addr_len;
      @(posedge i_clock) disable iff (i_rst)
         (stg_end && state_r == ST_ADDR && info_r.addr_mode == AM_MODE)
            |-> (stg_clk_r + 6'h01 == clocks(o_addr4_mode ? 6'h20 : 6'h18, lanes_r));
   endproperty
   a_addr_len: assert property (p_addr_len) else $error("address length wrong for mode"); // RULE4

   property p_fix32;
      @(posedge i_clock) disable iff (i_rst)
         (stg_end && state_r == ST_ADDR && info_r.addr_mode == AM_FIX32)
            |-> (stg_clk_r + 6'h01 == clocks(6'h20, lanes_r));
   endproperty
   a_fix32: assert property (p_fix32) else $error("fixed 32-bit address length wrong"); // RULE10

   property p_no_dummy;
      @(posedge i_clock) disable iff (i_rst)
         (stg_end && state_r == ST_ADDR && (op_r == OP_READ || op_r == OP_READ4)) |=> state_r == ST_DATA;
   endproperty
   a_no_dummy: assert property (p_no_dummy) else $error("plain read inserted dummy clocks"); // RULE9

   property p_dummy_len;
      @(posedge i_clock) disable iff (i_rst)
         (stg_end && state_r == ST_DUMMY) |-> (stg_clk_r + 6'h01 == info_r.dummy);
   endproperty
   a_dummy_len: assert property (p_dummy_len) else $error("dummy clock count wrong"); // RULE11

   property p_release;
      @(posedge i_clock) disable iff (i_rst)
         (state_r == ST_DUMMY || state_r == ST_DATA) ##1 (state_r != ST_GAP) |-> o_io_oe_n == 4'hf;
   endproperty
   a_release: assert property (p_release) else $error("host still drives during dummy or data"); // RULE14

   property p_busy;
      @(posedge i_clock) disable iff (i_rst)
         (state_r == ST_IDLE && i_cmd_valid && blocked) |=> state_r == ST_IDLE;
   endproperty
   a_busy: assert property (p_busy) else $error("read started while flash busy"); // RULE8

   property p_wrap_set;
      @(posedge i_clock) disable iff (i_rst)
         (stg_end && state_r == ST_WBITS) |=> o_wrap_bits == ($past(addr_r[7:0]) & 8'h70);
   endproperty
   a_wrap_set: assert property (p_wrap_set) else $error("wrap setting not captured"); // RULE22

   property p_cs_frame;
      @(posedge i_clock) disable iff (i_rst)
         (active && ph_r == PH_RISE) |=> (!o_cs_n && o_sclk);
   endproperty
   a_cs_frame: assert property (p_cs_frame) else $error("clock rose outside chip-select frame"); // RULE5

   c_enter4: cover property (@(posedge i_clock) disable iff (i_rst) stg_end && state_r == ST_OPC && op_r == OP_EN4B);
   c_quad_io: cover property (@(posedge i_clock) disable iff (i_rst) o_rd_valid && op_r == OP_QIO);
   c_dual: cover property (@(posedge i_clock) disable iff (i_rst) o_rd_valid && op_r == OP_DIO4);
   c_wrap: cover property (@(posedge i_clock) disable iff (i_rst) stg_end && state_r == ST_WBITS);
   c_refuse: cover property (@(posedge i_clock) disable iff (i_rst) state_r == ST_IDLE && i_cmd_valid && blocked);

endmodule

// *** tb/sfrp_flash_model.sv ***
// Behavioural serial flash die answering read, address-mode and wrap instructions at its pins.
`timescale 1ns/100ps
module sfrp_flash_model (
   input wire logic i_cs_n,
   input wire logic i_sclk,
   input wire logic [3:0] i_io,
   input wire logic [3:0] i_host_oe_n,
   input wire logic i_busy,
   output logic [3:0] o_io,
   output logic o_oe,
   output logic o_clash
);
   logic addr4_r = 1'b0;
   logic ign = 1'b1;
   logic rd;
   logic [7:0] wrap_r = 8'h10;
   logic [7:0] op;
   logic [3:0] v;
   logic [39:0] sh;
   logic [31:0] ad;
   int n, k, al, dl, ac, dm, alen, wl;
   initial begin
      o_io = 4'h0;
      o_oe = 1'b0;
      o_clash = 1'b0;
   end
   function automatic logic [7:0] dat(input logic [31:0] a);
      return a[7:0] ^ a[15:8] ^ a[31:24];
   endfunction
   always_comb begin
      rd = op inside {8'h03, 8'h13, 8'h0b, 8'h0c, 8'h3b, 8'h3c, 8'h6b, 8'h6c, 8'hbb, 8'hbc, 8'heb};
      alen = (addr4_r || op inside {8'h13, 8'h0c, 8'h3c, 8'h6c, 8'hbc}) ? 32 : 24;
      al = op inside {8'hbb, 8'hbc} ? 2 : op inside {8'heb, 8'h77} ? 4 : 1;
      dl = op inside {8'h3b, 8'h3c, 8'hbb, 8'hbc} ? 2 : op inside {8'h6b, 8'h6c, 8'heb} ? 4 : 1;
      dm = op inside {8'h03, 8'h13} ? 0 : op inside {8'hbb, 8'hbc} ? 4 : op == 8'heb ? 6 : 8;
      ac = (op == 8'h77 ? alen + 8 : alen) / al;
      wl = 8 << wrap_r[6:5];
   end
   // decode restarts; a busy die ignores the frame.
   always @(negedge i_cs_n) begin
      n = 0;
      k = 0;
      ign = i_busy;
   end
   // sample on rise; extended byte is zero.
   always @(posedge i_sclk) begin
      if (!i_cs_n && !ign) begin
         if (n < 8)
            op = {op[6:0], i_io[0]};
         else if (n < 8 + ac)
            sh = (sh << al) | 40'(i_io & 4'((1 << al) - 1));
         n = n + 1;
         if (n == 8 + ac)
            ad = alen == 32 ? sh[31:0] : {8'h00, sh[23:0]};
      end
   end
   always @(negedge i_sclk) begin
      if (!i_cs_n && !ign && rd && n >= 8 + ac + dm) begin
         o_oe = 1'b1;
         v = 4'((dat(ad) >> (8 - k - dl)) & ((1 << dl) - 1));
         o_io = dl == 1 ? v << 1 : v;
         o_clash = o_clash | (|(~i_host_oe_n & (dl == 1 ? 4'h2 : 4'((1 << dl) - 1))));
         k = k + dl;
         if (k == 8) begin
            k = 0;
            ad = (op == 8'heb && !wrap_r[4]) ? (ad & ~32'(wl - 1)) | ((ad + 1) & 32'(wl - 1)) : ad + 1;
         end
      end
   end
   // take effect when the frame closes.
   always @(posedge i_cs_n) begin
      o_oe = 1'b0;
      if (!ign && n == 8 && op == 8'hb7)
         addr4_r = 1'b1;
      if (!ign && n == 8 && op == 8'he9)
         addr4_r = 1'b0;
      if (!ign && op == 8'h77 && n == 8 + ac)
         wrap_r = sh[7:0] & 8'h70;
   end
endmodule

// *** tb/testbench.sv ***
// Self-checking bench for the serial flash read-path host controller.
`timescale 1ns/100ps
module testbench;
   logic i_clock = 1'b0, i_rst = 1'b1, i_cmd_valid = 1'b0, i_dev_busy = 1'b0;
   logic [7:0] i_cmd_opcode = 8'h00;
   logic [31:0] i_cmd_addr = 32'h0;
   logic [15:0] i_cmd_len_m1 = 16'h0;
   logic o_cmd_ready, o_rd_valid, o_addr4_mode, o_cs_n, o_sclk, fl_oe, clash;
   logic [7:0] o_rd_data, o_wrap_bits;
   logic [3:0] o_io_out, o_io_oe_n, fl_io, io_w;
   logic [7:0] ops [11] = '{8'h03, 8'h0b, 8'h3b, 8'h6b, 8'hbb, 8'heb, 8'h13, 8'h0c, 8'h3c, 8'h6c, 8'hbc};
   int n_fail = 0, n_compared = 0;
   always #12.5 i_clock = ~i_clock;
   // A released line shows the inverse of its last level so stale data cannot pass.
   assign io_w = (~o_io_oe_n & o_io_out) | (o_io_oe_n & (fl_oe ? fl_io : ~fl_io));
   sfrp_host_ctrl dut_u (.i_clock(i_clock), .i_rst(i_rst), .i_cmd_valid(i_cmd_valid),
      .i_cmd_opcode(i_cmd_opcode), .i_cmd_addr(i_cmd_addr), .i_cmd_len_m1(i_cmd_len_m1),
      .i_dev_busy(i_dev_busy), .o_cmd_ready(o_cmd_ready), .o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid),
      .o_addr4_mode(o_addr4_mode), .o_wrap_bits(o_wrap_bits), .o_cs_n(o_cs_n), .o_sclk(o_sclk),
      .o_io_out(o_io_out), .o_io_oe_n(o_io_oe_n), .i_io_in(io_w));
   sfrp_flash_model flash_u (.i_cs_n(o_cs_n), .i_sclk(o_sclk), .i_io(io_w), .i_host_oe_n(o_io_oe_n),
      .i_busy(i_dev_busy), .o_io(fl_io), .o_oe(fl_oe), .o_clash(clash));
   function automatic logic [31:0] dat(input logic [31:0] a);
      return 32'(a[7:0] ^ a[15:8] ^ a[31:24]);
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic finish_test;
      if (n_fail == 0 && n_compared > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic send(input logic [7:0] op, input logic [31:0] a, input int nb);
      int t;
      @(posedge i_clock);
      i_cmd_opcode <= op;
      i_cmd_addr <= a;
      i_cmd_len_m1 <= 16'(nb - 1);
      i_cmd_valid <= 1'b1;
      t = 0;
      do begin
         @(posedge i_clock);
         t++;
      end while (!(o_cmd_ready === 1'b1 && i_dev_busy === 1'b0) && t < 5000);
      if (t >= 5000)
         n_fail++;
      i_cmd_valid <= 1'b0;
   endtask
   task automatic idle;
      @(posedge i_clock iff o_cmd_ready === 1'b1);
   endtask
   task automatic rd(input logic [7:0] op, input logic [31:0] a, input logic [31:0] ea, input int nb, input int wl);
      send(op, a, nb);
      for (int i = 0; i < nb; i++) begin
         @(posedge i_clock iff o_rd_valid === 1'b1);
         check(32'(o_rd_data), dat(ea));
         ea = wl > 0 ? (ea & ~32'(wl - 1)) | ((ea + 1) & 32'(wl - 1)) : ea + 1;
      end
   endtask
   initial begin
      #2_000_000;
      n_fail++;
      finish_test;
   end
   initial begin
      repeat (5) @(posedge i_clock);
      i_rst <= 1'b0;
      @(posedge i_clock);
      check(32'(o_wrap_bits), 32'h10);
      check(32'({o_addr4_mode, o_cs_n, o_io_oe_n}), 32'h1f);
      // Read held back by a busy die must not reach the pins.
      i_dev_busy <= 1'b1;
      fork
         rd(8'h03, 32'hff000040, 32'h00000040, 2, 0);
         begin
            repeat (40) @(posedge i_clock);
            check(32'({o_cmd_ready, o_cs_n}), 32'h3);
            i_dev_busy <= 1'b0;
         end
      join
      for (int m = 0; m < 2; m++) begin
         if (m == 1) begin
            send(8'hb7, 32'h0, 1);
            idle;
            check(32'(o_addr4_mode), 32'h1);
         end
         foreach (ops[i])
            rd(ops[i], 32'h5a1234fe, (m == 1 || i > 5) ? 32'h5a1234fe : 32'h001234fe, 3, 0);
         for (int w = 0; w < 4; w++) begin
            send(8'h77, {24'h0, 1'b1, 2'(w), 5'h0a}, 1);
            idle;
            check(32'(o_wrap_bits), 32'({1'b0, 2'(w), 5'h00}));
            rd(8'heb, 32'h3c0012fd, m ? 32'h3c0012fd : 32'h000012fd, (8 << w) + 2, 8 << w);
         end
         send(8'h77, 32'h000000ff, 1);
         idle;
         check(32'(o_wrap_bits), 32'h70);
         rd(8'heb, 32'h3c0012fd, m ? 32'h3c0012fd : 32'h000012fd, 12, 0);
      end
      send(8'he9, 32'h0, 1);
      idle;
      check(32'(o_addr4_mode), 32'h0);
      rd(8'h03, 32'h7a0000fe, 32'h000000fe, 4, 0);
      check(32'(clash), 32'h0);
      finish_test;
   end
endmodule
